//--- src/vsr_status_regs.sv
// Status register bank of the voice recorder serial interface
`timescale 1ns/1ps
module vsr_status_regs
  import vsr_pkg::*;
(
  // System clock and reset
  input  wire logic              sys_clk_i,
  input  wire logic              rst_b_i,
  // Serial link from host
  input  wire logic              spi_sclk_i,
  input  wire logic              spi_ss_n_i,
  input  wire logic              spi_mosi_i,
  output logic                   spi_miso_o,
  output logic                   spi_miso_oe_o,
  // Engine events and levels
  input  wire logic              op_done_i,
  input  wire logic              end_marker_i,
  input  wire logic              powered_up_i,
  input  wire logic              spi_mode_i,
  input  wire logic              mem_full_set_i,
  input  wire logic              mem_erased_i,
  input  wire logic              cmd_reject_i,
  input  wire logic [ROW_W-1:0]  active_row_index_i,
  input  wire logic              set_buf_empty_i,
  input  wire logic              erasing_i,
  input  wire logic              playing_i,
  input  wire logic              recording_i,
  input  wire logic [SLOT_N-1:0] slot_recorded_i,
  input  wire logic [SLOT_N-1:0] slot_erased_i,
  // Decoded command and record inhibit to the engines
  output logic                   cmd_valid_o,
  output logic [7:0]             cmd_opcode_o,
  output logic                   rec_inhibit_o
);

  // Link side results
  logic [7:0]          link_cmd;
  logic [BITCNT_W-1:0] link_bits;
  logic                ss_s;

  // Frame tracking
  logic                ss_prev_q;
  logic                ss_prev_d;
  logic                frame_end;

  // Flags
  logic                err_q;
  logic                err_d;
  logic                full_q;
  logic                full_d;
  logic                pwr_q;
  logic                pwr_d;
  logic                end_q;
  logic                end_d;
  logic                int_q;
  logic                int_d;
  logic [ROW_W-1:0]    row_q;
  logic [ROW_W-1:0]    row_d;
  logic [3:0]          op_q;
  logic [3:0]          op_d;
  logic [SLOT_N-1:0]   slot_q;
  logic [SLOT_N-1:0]   slot_d;

  // Command decode
  logic [7:0]          opc;
  logic [2:0]          bytes;
  logic                bad_cmd;
  logic                clr_cmd;
  logic                cmd_valid_q;
  logic                cmd_valid_d;
  logic [7:0]          cmd_opc_q;
  logic [7:0]          cmd_opc_d;

  // Snapshot crossing to the link
  logic [PRI_W-1:0]    primary_status_word;
  logic [SEC_W-1:0]    secondary_status_byte;
  logic [STAT_W-1:0]   hold_q;
  logic [STAT_W-1:0]   hold_d;

  vsr_spi_link u_link (
    .sclk_i      (spi_sclk_i),
    .ss_n_i      (spi_ss_n_i),
    .rst_b_i     (rst_b_i),
    .mosi_i      (spi_mosi_i),
    .miso_o      (spi_miso_o),
    .miso_oe_o   (spi_miso_oe_o),
    .stat_i      (hold_q),
    .cmd_o       (link_cmd),
    .bit_count_o (link_bits)
  );

  vsr_sync #(
    .RST_VAL (1'b1)
  ) u_ss_sync (
    .clk_i   (sys_clk_i),
    .rst_b_i (rst_b_i),
    .d_i     (spi_ss_n_i),
    .q_o     (ss_s)
  );

  // Command and count are quiet once select rises, so read them at frame end
  always_comb
  begin
    ss_prev_d = ss_s;
    frame_end = ss_s & ~ss_prev_q;
    opc       = opc_core(link_cmd);
    bytes     = link_bits[5:3];
    bad_cmd   = (link_bits < BITS_CMD) ||
                (((opc & OPC_ADDR_MASK) == OPC_ADDR_GROUP) && (bytes < MIN_ADDR_BYTES));
    clr_cmd   = frame_end && !bad_cmd &&
                ((opc == OPC_CLEAR_IRQ) || (opc == OPC_RESET));
    cmd_valid_d = frame_end & ~bad_cmd;
    cmd_opc_d   = frame_end ? link_cmd : cmd_opc_q;
  end

  // Flag next values; engine sets win over a same-cycle clear
  always_comb
  begin
    if (frame_end)
      err_d = bad_cmd | cmd_reject_i;
    else
      err_d = err_q | cmd_reject_i;
    full_d = (full_q & ~mem_erased_i) | mem_full_set_i;
    pwr_d  = powered_up_i & spi_mode_i;
    end_d  = (end_q & ~clr_cmd) | end_marker_i;
    int_d  = (int_q & ~clr_cmd) | op_done_i;
    row_d  = active_row_index_i;
    op_d   = {recording_i, playing_i, erasing_i, set_buf_empty_i};
    slot_d = (slot_q & ~slot_erased_i) | slot_recorded_i;
  end

  always_ff @(posedge sys_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      ss_prev_q   <= 1'b1;
      err_q       <= PRI_RST[P_CMD_ERR];
      full_q      <= PRI_RST[P_FULL];
      pwr_q       <= PRI_RST[P_PWR];
      end_q       <= PRI_RST[P_END];
      int_q       <= PRI_RST[P_INT];
      row_q       <= ROW_RST;
      op_q        <= SEC_RST[S_REC:S_RDY];
      slot_q      <= SEC_RST[SEC_W-1:S_SLOT];
      cmd_valid_q <= 1'b0;
      cmd_opc_q   <= 8'h00;
    end
    else
    begin
      ss_prev_q   <= ss_prev_d;
      err_q       <= err_d;
      full_q      <= full_d;
      pwr_q       <= pwr_d;
      end_q       <= end_d;
      int_q       <= int_d;
      row_q       <= row_d;
      op_q        <= op_d;
      slot_q      <= slot_d;
      cmd_valid_q <= cmd_valid_d;
      cmd_opc_q   <= cmd_opc_d;
    end
  end

  // Status layout; no write path exists into either register
  always_comb
  begin
    primary_status_word   = {row_q[ROW_W-1:ROW_LO_W], row_q[ROW_LO_W-1:0],
                             int_q, end_q, pwr_q, full_q, err_q};
    secondary_status_byte = {slot_q[3], slot_q[2], slot_q[1], slot_q[0], op_q};
  end

  // Snapshot frozen while a frame runs: link reads a quasi-static word
  always_comb
  begin
    hold_d = ss_s ? {secondary_status_byte, primary_status_word} : hold_q;
  end

  always_ff @(posedge sys_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      hold_q <= {SEC_RST, PRI_RST};
    else
      hold_q <= hold_d;
  end

  assign cmd_valid_o   = cmd_valid_q;
  assign cmd_opcode_o  = cmd_opc_q;
  assign rec_inhibit_o = full_q;

endmodule : vsr_status_regs

//--- src/vsr_pkg.sv
// Constants shared by the voice recorder status register block
package vsr_pkg;

  // Field widths
  localparam int unsigned ROW_W      = 11;
  localparam int unsigned PRI_W      = 16;
  localparam int unsigned SEC_W      = 8;
  localparam int unsigned STAT_W     = PRI_W + SEC_W;
  localparam int unsigned BITCNT_W   = 6;

  // Primary status word bit positions
  localparam int unsigned P_CMD_ERR  = 0;
  localparam int unsigned P_FULL     = 1;
  localparam int unsigned P_PWR      = 2;
  localparam int unsigned P_END      = 3;
  localparam int unsigned P_INT      = 4;
  localparam int unsigned P_ROW_LO   = 5;
  localparam int unsigned P_ROW_HI   = 8;
  localparam int unsigned ROW_LO_W   = 3;
  localparam int unsigned ROW_HI_W   = 8;

  // Secondary status byte bit positions
  localparam int unsigned S_RDY      = 0;
  localparam int unsigned S_ERASE    = 1;
  localparam int unsigned S_PLAY     = 2;
  localparam int unsigned S_REC      = 3;
  localparam int unsigned S_SLOT     = 4;
  localparam int unsigned SLOT_N     = 4;

  // Reset values
  localparam logic [PRI_W-1:0]  PRI_RST    = 16'h0000;
  localparam logic [SEC_W-1:0]  SEC_RST    = 8'h00;
  localparam logic [ROW_W-1:0]  ROW_RST    = 11'h000;

  // Command opcodes, compared with the indicator-enable bit masked off
  localparam logic [7:0] OPC_MASK       = 8'hEF;
  localparam logic [7:0] OPC_RESET      = 8'h03;
  localparam logic [7:0] OPC_CLEAR_IRQ  = 8'h04;
  localparam logic [7:0] OPC_RD_STATUS  = 8'h05;
  localparam logic [7:0] OPC_ADDR_MASK  = 8'hEC;
  localparam logic [7:0] OPC_ADDR_GROUP = 8'h80;

  // Frame lengths
  localparam logic [2:0]          BYTE_RD_STATUS = 3'h2;
  localparam logic [BITCNT_W-1:0] BITS_CMD       = 6'h08;
  localparam logic [BITCNT_W-1:0] BITCNT_MAX     = 6'h3F;
  localparam logic [2:0]          MIN_ADDR_BYTES = 3'h5;

  // Setup from select low to first serial clock edge
  localparam int unsigned SYS_CLK_NS     = 50;
  localparam int unsigned SS_SETUP_NS    = 150;
  localparam int unsigned SS_SETUP_CYC   = (SS_SETUP_NS + SYS_CLK_NS - 1) / SYS_CLK_NS;

  function automatic logic [7:0] opc_core(input logic [7:0] opc);
    opc_core = opc & OPC_MASK;
  endfunction : opc_core

endpackage : vsr_pkg

//--- src/vsr_sync.sv
// Two-stage level synchroniser
`timescale 1ns/1ps
module vsr_sync
  import vsr_pkg::*;
#(
  parameter logic RST_VAL = 1'b1
)
(
  // Clock and reset
  input  wire logic clk_i,
  input  wire logic rst_b_i,
  // Level
  input  wire logic d_i,
  output logic      q_o
);

  logic meta_q;
  logic meta_d;
  logic sync_q;
  logic sync_d;

  always_comb
  begin
    meta_d = d_i;
    sync_d = meta_q;
  end

  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      meta_q <= RST_VAL;
      sync_q <= RST_VAL;
    end
    else
    begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end

  assign q_o = sync_q;

endmodule : vsr_sync

//--- src/vsr_spi_link.sv
// Serial-clock side shifter: receives command, returns status bytes
`timescale 1ns/1ps
module vsr_spi_link
  import vsr_pkg::*;
(
  // Link clock and resets
  input  wire logic                sclk_i,
  input  wire logic                ss_n_i,
  input  wire logic                rst_b_i,
  // Serial data
  input  wire logic                mosi_i,
  output logic                     miso_o,
  output logic                     miso_oe_o,
  // Frozen status snapshot from system side
  input  wire logic [STAT_W-1:0]   stat_i,
  // Frame results, stable once the clock stops
  output logic [7:0]               cmd_o,
  output logic [BITCNT_W-1:0]      bit_count_o
);

  logic                link_rst_b;
  logic                act_q;
  logic                act_d;
  logic [BITCNT_W-1:0] cnt_q;
  logic [BITCNT_W-1:0] cnt_d;
  logic [7:0]          sh_q;
  logic [7:0]          sh_d;
  logic [7:0]          cmd_q;
  logic [7:0]          cmd_d;
  logic                miso_q;
  logic                miso_d;
  logic                oe_q;
  logic [BITCNT_W-1:0] idx;
  logic [7:0]          out_byte;

  // Frame state drops whenever select is high
  assign link_rst_b = rst_b_i & ~ss_n_i;

  always_comb
  begin
    act_d = 1'b1;
    sh_d  = {mosi_i, sh_q[7:1]};
    cnt_d = act_q ? ((cnt_q == BITCNT_MAX) ? cnt_q : cnt_q + 6'h01) : 6'h01;
    cmd_d = (cnt_d == BITS_CMD) ? {mosi_i, sh_q[7:1]} : cmd_q;
  end

  always_ff @(posedge sclk_i or negedge link_rst_b)
  begin
    if (!link_rst_b)
      act_q <= 1'b0;
    else
      act_q <= act_d;
  end

  // Count and command survive select going high for the system side
  always_ff @(posedge sclk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      cnt_q <= '0;
      sh_q  <= 8'h00;
      cmd_q <= 8'h00;
    end
    else
    begin
      cnt_q <= cnt_d;
      sh_q  <= sh_d;
      cmd_q <= cmd_d;
    end
  end

  // Byte 2 of a status read is the secondary byte, all others alternate primary low/high
  always_comb
  begin
    idx = act_q ? cnt_q : '0;
    if ((idx[5:3] == BYTE_RD_STATUS) && (opc_core(cmd_q) == OPC_RD_STATUS))
      out_byte = stat_i[STAT_W-1:PRI_W];
    else if (idx[3])
      out_byte = stat_i[PRI_W-1:P_ROW_HI];
    else
      out_byte = stat_i[7:0];
    miso_d = out_byte[idx[2:0]];
  end

  // Mode 3: data changes on falling edge, first falling edge loads bit 0
  always_ff @(negedge sclk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      miso_q <= 1'b0;
    else
      miso_q <= miso_d;
  end

  always_ff @(negedge sclk_i or negedge link_rst_b)
  begin
    if (!link_rst_b)
      oe_q <= 1'b0;
    else
      oe_q <= 1'b1;
  end

  assign miso_o      = miso_q;
  assign miso_oe_o   = oe_q;
  assign cmd_o       = cmd_q;
  assign bit_count_o = cnt_q;

endmodule : vsr_spi_link

//--- sim/vsr_status_regs_assertions.sv
// Port-level assertions for the status register bank
`timescale 1ns/1ps
module vsr_status_regs_chk
  import vsr_pkg::*;
(
  // Clocks and reset
  input wire logic sys_clk_i,
  input wire logic rst_b_i,
  input wire logic spi_sclk_i,
  // Watched ports
  input wire logic spi_ss_n_i,
  input wire logic spi_miso_oe_o,
  input wire logic mem_full_set_i,
  input wire logic mem_erased_i,
  input wire logic cmd_valid_o,
  input wire logic rec_inhibit_o
);
  // Four low samples put the last frame end beyond the pulse latency
  sequence s_selected;
    !spi_ss_n_i [*4];
  endsequence
  sequence s_quiet;
    !cmd_valid_o [*2];
  endsequence

  // Two clock domains watched here, so each property names its own clock
  a_full_sets: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
    mem_full_set_i |=> rec_inhibit_o)
    else $error("inhibit not set");
  a_full_clears: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
    (mem_erased_i && !mem_full_set_i) |=> !rec_inhibit_o)
    else $error("inhibit not cleared");
  a_inhibit_cause: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
    $rose(rec_inhibit_o) |-> $past(mem_full_set_i))
    else $error("inhibit rose unprompted");
  a_valid_pulse: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
    cmd_valid_o |=> s_quiet)
    else $error("valid too long");
  a_valid_after_frame: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
    (!spi_ss_n_i || !$past(spi_ss_n_i)) |-> !cmd_valid_o)
    else $error("valid before frame end");
  a_quiet_in_frame: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
    s_selected |-> !cmd_valid_o)
    else $error("valid inside frame");
  a_oe_released: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
    spi_ss_n_i |-> !spi_miso_oe_o)
    else $error("output driven unselected");
  a_oe_in_frame: assert property (@(posedge spi_sclk_i) disable iff (!rst_b_i)
    !spi_ss_n_i |-> spi_miso_oe_o)
    else $error("output idle in frame");
endmodule : vsr_status_regs_chk

bind vsr_status_regs vsr_status_regs_chk u_chk (
  .sys_clk_i, .rst_b_i, .spi_sclk_i, .spi_ss_n_i, .spi_miso_oe_o,
  .mem_full_set_i, .mem_erased_i, .cmd_valid_o, .rec_inhibit_o
);

//--- sim/vsr_host_model.sv
// Host controller model for the serial link, mode 3, LSB first
`timescale 1ns/1ps
module vsr_host_model
  import vsr_pkg::*;
(
  // Link to device
  output logic      spi_sclk_o,
  output logic      spi_ss_n_o,
  output logic      spi_mosi_o,
  input  wire logic spi_miso_i,
  input  wire logic spi_miso_oe_i
);
  initial
  begin
    spi_sclk_o = 1'b1;
    spi_ss_n_o = 1'b1;
    spi_mosi_o = 1'b0;
  end

  // Clock runs only inside frames; short counts are asked for on purpose
  task automatic xfer(input int nbits, input logic [55:0] tx, output logic [55:0] rx);
    rx = '0;
    #7 spi_ss_n_o = 1'b0;
    #(SS_SETUP_NS + 10);
    for (int i = 0; i < nbits; i++)
    begin
      spi_sclk_o = 1'b0;
      spi_mosi_o = tx[i];
      #6 spi_sclk_o = 1'b1;
      rx[i] = spi_miso_oe_i ? spi_miso_i : 1'bx;
      #6;
    end
    #20 spi_ss_n_o = 1'b1;
    spi_mosi_o = 1'b0;
    #200;
  endtask : xfer
endmodule : vsr_host_model

//--- sim/vsr_status_regs_tb.sv
// Self-checking bench for the status register bank
`timescale 1ns/1ps
module vsr_status_regs_tb
  import vsr_pkg::*;
;
  typedef struct packed {
    logic [ROW_W-1:0] row;
    logic [5:0]       lvl;
    logic [15:0]      pri;
    logic [7:0]       sec;
  } vsr_row_s;
  // Levels: power, serial mode, record, play, erase, ready
  localparam vsr_row_s tbl [4] = '{
    '{11'h7FF, 6'h31, 16'hFFE4, 8'h01}, '{11'h001, 6'h22, 16'h0020, 8'h02},
    '{11'h400, 6'h14, 16'h8000, 8'h04}, '{11'h2AA, 6'h38, 16'h5544, 8'h08}};

  logic             sys_clk_i = 1'b0;
  logic             rst_b_i = 1'b0;
  logic             sclk, ss_n, mosi, miso, miso_oe, cmd_valid, rec_inh;
  logic             op_done, end_mk, pwr, mode, full_set, erased, reject, rdy, era, play, rec;
  logic [ROW_W-1:0] row;
  logic [3:0]       slot_rec, slot_era;
  logic [7:0]       opcode;
  logic [55:0]      rx;
  int               n_errors = 0;
  int               checked = 0;
  int               n_valid = 0;
  int               nv;

  vsr_status_regs dut (
    .sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i), .spi_sclk_i(sclk), .spi_ss_n_i(ss_n),
    .spi_mosi_i(mosi), .spi_miso_o(miso), .spi_miso_oe_o(miso_oe), .op_done_i(op_done),
    .end_marker_i(end_mk), .powered_up_i(pwr), .spi_mode_i(mode), .mem_full_set_i(full_set),
    .mem_erased_i(erased), .cmd_reject_i(reject), .active_row_index_i(row),
    .set_buf_empty_i(rdy), .erasing_i(era), .playing_i(play), .recording_i(rec),
    .slot_recorded_i(slot_rec), .slot_erased_i(slot_era), .cmd_valid_o(cmd_valid),
    .cmd_opcode_o(opcode), .rec_inhibit_o(rec_inh)
  );
  vsr_host_model host (
    .spi_sclk_o(sclk), .spi_ss_n_o(ss_n), .spi_mosi_o(mosi), .spi_miso_i(miso),
    .spi_miso_oe_i(miso_oe)
  );

  always #25 sys_clk_i = ~sys_clk_i;
  always @(posedge sys_clk_i)
    if (cmd_valid === 1'b1)
      n_valid <= n_valid + 1;

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic stop_test;
    $display("errors=%0d checks=%0d", n_errors, checked);
    if (n_errors == 0 && checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : stop_test

  // Bytes after the command are all ones: a host write attempt
  task automatic frame(input int nbits, input logic [7:0] cmd);
    repeat (4) @(posedge sys_clk_i);
    host.xfer(nbits, {48'hFFFF_FFFF_FFFF, cmd}, rx);
    repeat (5) @(posedge sys_clk_i);
  endtask : frame

  // Bits: done, end, full, erased, reject, slots recorded, slots erased
  task automatic pulse(input logic [12:0] v);
    @(posedge sys_clk_i);
    {op_done, end_mk, full_set, erased, reject, slot_rec, slot_era} <= v;
    @(posedge sys_clk_i);
    {op_done, end_mk, full_set, erased, reject, slot_rec, slot_era} <= '0;
  endtask : pulse

  initial
  begin
    repeat (20000) @(posedge sys_clk_i);
    n_errors++;
    stop_test;
  end

  initial
  begin
    {op_done, end_mk, pwr, mode, full_set, erased, reject, rdy, era, play, rec} = '0;
    {slot_rec, slot_era, row} = '0;
    repeat (2) @(posedge sys_clk_i);
    rst_b_i <= 1'b1;
    foreach (tbl[k])
    begin
      {pwr, mode, rec, play, era, rdy} <= tbl[k].lvl;
      row <= tbl[k].row;
      frame(24, OPC_RD_STATUS);
      check(rx[15:0], tbl[k].pri);
      check({8'h00, rx[23:16]}, {8'h00, tbl[k].sec});
    end
    pulse(13'h1CF0);
    frame(24, OPC_RD_STATUS);
    check(rx[15:0], 16'h555E);
    check({8'h00, rx[23:16]}, 16'h00F8);
    check({15'h0000, rec_inh}, 16'h0001);
    pulse(13'h0205);
    nv = n_valid;
    frame(16, 8'h14);
    check(rx[15:0], 16'h555C);
    check({8'h00, opcode}, 16'h0014);
    frame(56, OPC_RD_STATUS);
    check(rx[15:0], 16'h5544);
    check({8'h00, rx[23:16]}, 16'h00A8);
    check(rx[47:32], 16'h5544);
    check({8'h00, rx[55:48]}, 16'h0044);
    check(16'(n_valid - nv), 16'h0002);
    // Short addressed frame, then a frame cut inside the command byte
    nv = n_valid;
    frame(16, 8'h81);
    frame(24, OPC_RD_STATUS);
    check(rx[15:0], 16'h5545);
    frame(5, OPC_CLEAR_IRQ);
    frame(24, OPC_RD_STATUS);
    check(rx[15:0], 16'h5545);
    check(16'(n_valid - nv), 16'h0002);
    pulse(13'h0100);
    frame(24, OPC_RD_STATUS);
    check(rx[15:0], 16'h5545);
    frame(24, OPC_RD_STATUS);
    check(rx[15:0], 16'h5544);
    // Full addressed frame, then the reset command with its indicator bit set
    pulse(13'h1800);
    nv = n_valid;
    frame(40, OPC_ADDR_GROUP | 8'h03);
    check(rx[15:0], 16'h555C);
    frame(8, OPC_RESET | 8'h10);
    check({8'h00, rx[7:0]}, 16'h005C);
    frame(24, OPC_RD_STATUS);
    check(rx[15:0], 16'h5544);
    check(16'(n_valid - nv), 16'h0003);
    pulse(13'h0400);
    @(posedge sys_clk_i);
    rst_b_i <= 1'b0;
    @(posedge sys_clk_i);
    #1;
    check({6'h00, rec_inh, miso_oe, opcode}, 16'h0000);
    @(posedge sys_clk_i);
    rst_b_i <= 1'b1;
    frame(24, OPC_RD_STATUS);
    check(rx[15:0], 16'h5544);
    check({8'h00, rx[23:16]}, 16'h0008);
    stop_test;
  end
endmodule : vsr_status_regs_tb
